// ---- design/mgpio_top.sv ----
// register core and pin control of the four-port gpio bank
`timescale 1ns/1ns

// Functional notes
// - per-bit port1 direction, one drives latch
// - reset clears port1 direction and latch
// - port1 read returns latch for outputs
// - port1 read returns pin for inputs
// - port2 three latch bits reset high
// - dual clock gives pins 1-2 to crystal
// - falling port2 bit0 gives a one-cycle interrupt pulse
// - stop mode floats port2 bit0
// - port2 reads valid only in low bits
// - port3 latch resets to all ones
// - ports 2-4 have latch and pin registers
// - port4 type bit picks drain or push
// - port4 latch ones, type zero at reset
module mgpio_top (
    input  wire logic                          mclk,
    input  wire logic                          nrst,
    input  wire logic [mgpio_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [mgpio_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [mgpio_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                          global_output_gate,
    input  wire logic                          dual_clock_mode,
    input  wire logic                          stop_mode,
    input  wire logic [mgpio_pkg::PORT_W-1:0]  p1_pin_in,
    output logic      [mgpio_pkg::PORT_W-1:0]  p1_pin_out,
    output logic      [mgpio_pkg::PORT_W-1:0]  p1_pin_oe,
    input  wire logic [mgpio_pkg::PORT_W-1:0]  p1_periph_out,
    output logic      [mgpio_pkg::PORT_W-1:0]  p1_level,
    input  wire logic [mgpio_pkg::P2_W-1:0]    p2_pin_in,
    output logic      [mgpio_pkg::P2_W-1:0]    p2_pin_out,
    output logic      [mgpio_pkg::P2_W-1:0]    p2_pin_oe,
    input  wire logic                          low_freq_crystal_out,
    output logic                               low_freq_crystal_in,
    output logic                               stop_release_pin,
    output logic                               ext_int0_fall,
    input  wire logic [mgpio_pkg::PORT_W-1:0]  p3_pin_in,
    output logic      [mgpio_pkg::PORT_W-1:0]  p3_pin_out,
    output logic      [mgpio_pkg::PORT_W-1:0]  p3_pin_oe,
    input  wire logic [mgpio_pkg::PORT_W-1:0]  p4_pin_in,
    output logic      [mgpio_pkg::PORT_W-1:0]  p4_pin_out,
    output logic      [mgpio_pkg::PORT_W-1:0]  p4_pin_oe,
    input  wire logic [mgpio_pkg::PORT_W-1:0]  p4_periph_out,
    output logic      [mgpio_pkg::PORT_W-1:0]  p4_level
);
    import mgpio_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [PORT_W-1:0] p1_data;
        logic [PORT_W-1:0] p1_dir;
        logic [P2_W-1:0]   p2_data;
        logic [PORT_W-1:0] p3_data;
        logic [PORT_W-1:0] p4_data;
        logic [PORT_W-1:0] p4_type;
        logic [DATA_W-1:0] rdata;
        logic [PORT_W-1:0] p1_lvl;
        logic [PORT_W-1:0] p4_lvl;
        logic              p20_lvl;
        logic              p20_fall;
        logic              xtal_in;
    } mgpio_regs_t;

    mgpio_regs_t r_q;
    mgpio_regs_t r_d;
    logic        rst_n;

    mgpio_drv_if #(.W(PORT_W)) d1 ();
    mgpio_drv_if #(.W(P2_W))   d2 ();
    mgpio_drv_if #(.W(PORT_W)) d3 ();
    mgpio_drv_if #(.W(PORT_W)) d4 ();

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    mgpio_rst_sync u_rst (
        .mclk  (mclk),
        .nrst  (nrst),
        .rst_n (rst_n)
    );

    // ------------------------------------------------------------------
    // register file, read path and pin sampling
    // ------------------------------------------------------------------
    // input-mode port1 bits read the pin, so a read-modify-write on a
    // mixed-direction byte copies pin levels into those latches
    always_comb begin
        r_d = r_q;
        if (reg_wr) begin
            if (mgpio_hit(reg_addr, OFF_P1_DATA)) r_d.p1_data = reg_wdata;
            if (mgpio_hit(reg_addr, OFF_P1_DIR))  r_d.p1_dir  = reg_wdata;
            if (mgpio_hit(reg_addr, OFF_P2_DATA)) r_d.p2_data = reg_wdata[P2_W-1:0];
            if (mgpio_hit(reg_addr, OFF_P3_DATA)) r_d.p3_data = reg_wdata;
            if (mgpio_hit(reg_addr, OFF_P4_DATA)) r_d.p4_data = reg_wdata;
            if (mgpio_hit(reg_addr, OFF_P4_TYPE)) r_d.p4_type = reg_wdata;
        end
        // read data stands for one cycle only; unmapped reads give zero
        r_d.rdata = '0;
        if (reg_rd) begin
            if (mgpio_hit(reg_addr, OFF_P1_DATA))
                r_d.rdata = (r_q.p1_dir & r_q.p1_data) | (~r_q.p1_dir & p1_pin_in);
            if (mgpio_hit(reg_addr, OFF_P1_DIR))  r_d.rdata = r_q.p1_dir;
            if (mgpio_hit(reg_addr, OFF_P2_DATA)) r_d.rdata = {5'h00, r_q.p2_data};
            if (mgpio_hit(reg_addr, OFF_P2_PINS)) r_d.rdata = {5'h00, p2_pin_in};
            if (mgpio_hit(reg_addr, OFF_P3_DATA)) r_d.rdata = r_q.p3_data;
            if (mgpio_hit(reg_addr, OFF_P3_PINS)) r_d.rdata = p3_pin_in;
            if (mgpio_hit(reg_addr, OFF_P4_DATA)) r_d.rdata = r_q.p4_data;
            if (mgpio_hit(reg_addr, OFF_P4_TYPE)) r_d.rdata = r_q.p4_type;
            if (mgpio_hit(reg_addr, OFF_P4_PINS)) r_d.rdata = p4_pin_in;
        end
        // pin levels handed on to the peripherals
        r_d.p1_lvl   = p1_pin_in;
        r_d.p4_lvl   = p4_pin_in;
        r_d.xtal_in  = p2_pin_in[P2_XIN_BIT] & dual_clock_mode;
        r_d.p20_lvl  = p2_pin_in[P2_STOP_BIT];
        // edge seen on the pad itself, so a driven low also triggers
        r_d.p20_fall = r_q.p20_lvl & ~p2_pin_in[P2_STOP_BIT];
    end

    // reset values put port1 in input mode and ports 2-4 latches high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_q.p1_data  <= RST_P1_DATA;
            r_q.p1_dir   <= RST_P1_DIR;
            r_q.p2_data  <= RST_P2_DATA;
            r_q.p3_data  <= RST_P3_DATA;
            r_q.p4_data  <= RST_P4_DATA;
            r_q.p4_type  <= RST_P4_TYPE;
            r_q.rdata    <= '0;
            r_q.p1_lvl   <= '0;
            r_q.p4_lvl   <= '0;
            r_q.p20_lvl  <= 1'b1;
            r_q.p20_fall <= 1'b0;
            r_q.xtal_in  <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // ------------------------------------------------------------------
    // drive requests
    // ------------------------------------------------------------------
    // port1 push-pull where direction is set, peripheral gated by latch
    assign d1.en   = r_q.p1_dir & {PORT_W{global_output_gate}};
    assign d1.push = '1;
    assign d1.val  = r_q.p1_data & p1_periph_out;

    // port2 open drain, crystal out push-pull in dual clock; stop bit follows the gate and floats in stop
    always_comb begin
        d2.en   = {P2_W{global_output_gate}};
        d2.push = '0;
        d2.val  = r_q.p2_data;
        d2.en[P2_STOP_BIT] = ~stop_mode & global_output_gate;
        if (dual_clock_mode) begin
            d2.en[P2_XIN_BIT]    = 1'b0;
            d2.en[P2_XOUT_BIT]   = 1'b1;
            d2.push[P2_XOUT_BIT] = 1'b1;
            d2.val[P2_XOUT_BIT]  = low_freq_crystal_out;
        end
    end

    // port3 sink-only large-current port
    assign d3.en   = {PORT_W{global_output_gate}};
    assign d3.push = '0;
    assign d3.val  = r_q.p3_data;

    // port4 type selects push-pull or open drain per bit
    assign d4.en   = {PORT_W{global_output_gate}};
    assign d4.push = r_q.p4_type;
    assign d4.val  = r_q.p4_data & p4_periph_out;

    // ------------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------------
    mgpio_pad #(.W(PORT_W)) u_p1 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .drv     (d1.pad),
        .pin_out (p1_pin_out),
        .pin_oe  (p1_pin_oe)
    );

    mgpio_pad #(.W(P2_W)) u_p2 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .drv     (d2.pad),
        .pin_out (p2_pin_out),
        .pin_oe  (p2_pin_oe)
    );

    mgpio_pad #(.W(PORT_W)) u_p3 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .drv     (d3.pad),
        .pin_out (p3_pin_out),
        .pin_oe  (p3_pin_oe)
    );

    mgpio_pad #(.W(PORT_W)) u_p4 (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .drv     (d4.pad),
        .pin_out (p4_pin_out),
        .pin_oe  (p4_pin_oe)
    );

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata           = r_q.rdata;
    assign p1_level            = r_q.p1_lvl;
    assign p4_level            = r_q.p4_lvl;
    assign low_freq_crystal_in = r_q.xtal_in;
    assign stop_release_pin    = r_q.p20_lvl;
    assign ext_int0_fall       = r_q.p20_fall;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_p1_dir_gate: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((p1_pin_oe & ~$past(r_q.p1_dir)) == '0))
        else $error("port1 pin driven while direction is input");

    a_p1_reset_in: assert property (@(posedge mclk)
        $rose(rst_n) |-> (r_q.p1_dir == RST_P1_DIR && r_q.p1_data == RST_P1_DATA))
        else $error("port1 not input after reset");

    a_p1_read_mix: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P1_DATA) |=>
        reg_rdata == (($past(r_q.p1_dir) & $past(r_q.p1_data)) | (~$past(r_q.p1_dir) & $past(p1_pin_in))))
        else $error("port1 read mixes latch and pin wrongly");

    a_p1_and_out: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((p1_pin_oe & (p1_pin_out ^ ($past(r_q.p1_data) & $past(p1_periph_out)))) == '0))
        else $error("port1 output not latch and peripheral");

    a_p2_reset_hi: assert property (@(posedge mclk)
        $rose(rst_n) |-> r_q.p2_data == RST_P2_DATA && r_q.p3_data == RST_P3_DATA)
        else $error("port2 or port3 latch not high after reset");

    a_xtal_pins: assert property (@(posedge mclk) disable iff (!rst_n)
        dual_clock_mode |=> !p2_pin_oe[P2_XIN_BIT])
        else $error("crystal input pin driven in dual clock");

    a_p20_fall: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(p2_pin_in[P2_STOP_BIT]) |=> ext_int0_fall ##1 !ext_int0_fall)
        else $error("falling stop pin not flagged once");

    a_stop_float: assert property (@(posedge mclk) disable iff (!rst_n)
        stop_mode |=> !p2_pin_oe[P2_STOP_BIT])
        else $error("stop pin driven in stop mode");

    a_p2_upper: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && (reg_addr == OFF_P2_DATA || reg_addr == OFF_P2_PINS)) |=> reg_rdata[7:3] == 5'h00)
        else $error("port2 upper read bits not zero");

    a_p3_pin_read: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P3_PINS) |=> reg_rdata == $past(p3_pin_in))
        else $error("port3 pin read mismatch");

    a_p4_drain: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 ((p4_pin_oe & p4_pin_out & ~$past(r_q.p4_type)) == '0))
        else $error("open drain port4 pin driven high");

    a_p4_reset: assert property (@(posedge mclk)
        $rose(rst_n) |-> r_q.p4_data == RST_P4_DATA && r_q.p4_type == RST_P4_TYPE)
        else $error("port4 reset values wrong");

    a_p3_od_low: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (p3_pin_oe == (~$past(r_q.p3_data) & {PORT_W{$past(global_output_gate)}})))
        else $error("port3 open drain not pulling only zeros");

    a_p1_read_in: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P1_DATA) |=> ((reg_rdata ^ $past(p1_pin_in)) & ~$past(r_q.p1_dir)) == '0)
        else $error("port1 input bit read not the pin");

    a_p1_oe_exact: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (p1_pin_oe == ($past(r_q.p1_dir) & {PORT_W{$past(global_output_gate)}})))
        else $error("port1 output bit not driven");

    a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside read");

    a_p2_data_rd: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P2_DATA) |=> reg_rdata[P2_W-1:0] == $past(r_q.p2_data))
        else $error("port2 latch read mismatch");

    a_p2_pin_rd: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P2_PINS) |=> reg_rdata[P2_W-1:0] == $past(p2_pin_in))
        else $error("port2 pin read mismatch");

    a_p3_data_rd: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P3_DATA) |=> reg_rdata == $past(r_q.p3_data))
        else $error("port3 latch read mismatch");

    a_p4_data_rd: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P4_DATA) |=> reg_rdata == $past(r_q.p4_data))
        else $error("port4 latch read mismatch");

    a_p4_pin_rd: assert property (@(posedge mclk) disable iff (!rst_n)
        (reg_rd && reg_addr == OFF_P4_PINS) |=> reg_rdata == $past(p4_pin_in))
        else $error("port4 pin read mismatch");

    a_p4_push_oe: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (((p4_pin_oe ^ {PORT_W{$past(global_output_gate)}}) & $past(r_q.p4_type)) == '0))
        else $error("push-pull port4 pin not enabled by gate");

    a_p4_push_val: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (((p4_pin_out ^ ($past(r_q.p4_data) & $past(p4_periph_out))) & $past(r_q.p4_type)) == '0))
        else $error("push-pull port4 pin value wrong");

    a_p4_od_low: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (((p4_pin_oe ^ ({PORT_W{$past(global_output_gate)}} & ~($past(r_q.p4_data) & $past(p4_periph_out))))
            & ~$past(r_q.p4_type)) == '0))
        else $error("open drain port4 pin not pulling only zeros");

    a_xtal_out: assert property (@(posedge mclk) disable iff (!rst_n)
        dual_clock_mode |=> p2_pin_oe[P2_XOUT_BIT] && p2_pin_out[P2_XOUT_BIT] == $past(low_freq_crystal_out))
        else $error("crystal output pin not driven in dual clock");

    a_xtal_in: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (low_freq_crystal_in == ($past(p2_pin_in[P2_XIN_BIT]) && $past(dual_clock_mode))))
        else $error("crystal input level not gated by mode");

    a_stop_level: assert property (@(posedge mclk) disable iff (!rst_n)
        ##1 (stop_release_pin == $past(p2_pin_in[P2_STOP_BIT])))
        else $error("stop release level not following pin");

    a_int_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        !$fell(p2_pin_in[P2_STOP_BIT]) |=> !ext_int0_fall)
        else $error("interrupt pulse without falling pin");

endmodule : mgpio_top

// ---- design/mgpio_pkg.sv ----
// constants for the multi-port gpio bank
package mgpio_pkg;

    // ------------------------------------------------------------------
    // bus and port widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PORT_W = 8;
    localparam int P2_W   = 3;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_P1_DATA  = 12'h001;
    localparam logic [ADDR_W-1:0] OFF_P2_DATA  = 12'h002;
    localparam logic [ADDR_W-1:0] OFF_P3_DATA  = 12'h003;
    localparam logic [ADDR_W-1:0] OFF_P4_DATA  = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_P1_DIR   = 12'h009;
    localparam logic [ADDR_W-1:0] OFF_P4_TYPE  = 12'h00a;
    localparam logic [ADDR_W-1:0] OFF_P2_PINS  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_P3_PINS  = 12'h00d;
    localparam logic [ADDR_W-1:0] OFF_P4_PINS  = 12'h00e;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [PORT_W-1:0] RST_P1_DATA = 8'h00;
    localparam logic [PORT_W-1:0] RST_P1_DIR  = 8'h00;
    localparam logic [P2_W-1:0]   RST_P2_DATA = 3'h7;
    localparam logic [PORT_W-1:0] RST_P3_DATA = 8'hff;
    localparam logic [PORT_W-1:0] RST_P4_DATA = 8'hff;
    localparam logic [PORT_W-1:0] RST_P4_TYPE = 8'h00;

    // ------------------------------------------------------------------
    // port 2 bit positions and reset synchroniser depth
    // ------------------------------------------------------------------
    localparam int P2_STOP_BIT = 0;
    localparam int P2_XIN_BIT  = 1;
    localparam int P2_XOUT_BIT = 2;
    localparam int SYNC_STAGES = 2;

    // address match, shared by write and read decode
    function automatic logic mgpio_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        return addr == off;
    endfunction : mgpio_hit

endpackage : mgpio_pkg

// ---- design/mgpio_drv_if.sv ----
// drive request from the register core to one pin driver
`timescale 1ns/1ns
interface mgpio_drv_if #(parameter int W = 8);
    logic [W-1:0] en;
    logic [W-1:0] push;
    logic [W-1:0] val;
    modport src (output en, output push, output val);
    modport pad (input en, input push, input val);
endinterface : mgpio_drv_if

// ---- design/mgpio_rst_sync.sv ----
// two-stage release synchroniser for the async low reset
`timescale 1ns/1ns
module mgpio_rst_sync (
    input  wire logic mclk,
    input  wire logic nrst,
    output logic      rst_n
);
    import mgpio_pkg::*;

    typedef struct packed {
        logic [SYNC_STAGES-1:0] sh;
    } mgpio_rs_t;

    mgpio_rs_t s_q;
    mgpio_rs_t s_d;

    // shift ones in after release; assert is immediate
    always_comb begin
        s_d.sh = {s_q.sh[SYNC_STAGES-2:0], 1'b1};
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rst_n = s_q.sh[SYNC_STAGES-1];

endmodule : mgpio_rst_sync

// ---- design/mgpio_pad.sv ----
// registered pin driver: push-pull or sink-only open drain per bit
`timescale 1ns/1ns
module mgpio_pad #(
    parameter int W = 8
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    mgpio_drv_if.pad   drv,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe
);
    import mgpio_pkg::*;

    if (W < 1 || W > PORT_W) begin : g_chk
        $error("mgpio_pad: width out of range");
    end

    typedef struct packed {
        logic [W-1:0] out;
        logic [W-1:0] oe;
    } mgpio_pad_t;

    mgpio_pad_t p_q;
    mgpio_pad_t p_d;

    // open drain only ever pulls low; a one leaves the pin free as input
    always_comb begin
        p_d.out = drv.val & drv.push;
        p_d.oe  = drv.en & (drv.push | ~drv.val);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p_q <= '0;
        end else begin
            p_q <= p_d;
        end
    end

    assign pin_out = p_q.out;
    assign pin_oe  = p_q.oe;

endmodule : mgpio_pad

// ---- verif/mgpio_pad_model.sv ----
// partner model of the pads: device drive, outside source or pull-up per pin
`timescale 1ns/1ns
module mgpio_pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    input  wire logic [W-1:0] ext_val,
    input  wire logic [W-1:0] ext_en,
    output logic      [W-1:0] level
);
    // ------------------------------------------------------------------
    // pad resolution
    // ------------------------------------------------------------------
    // a released pad with no outside source falls to the pull-up, so an old low never lingers
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : mgpio_pad_model

// ---- verif/tb_top.sv ----
// self-checking bench of the four-port gpio bank
`timescale 1ns/1ns
module tb_top;
    import mgpio_pkg::*;
    logic              mclk = 1'b0;
    logic              nrst = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0]        reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [7:0]        reg_rdata;
    logic              gate = 1'b1;
    logic              dual = 1'b0;
    logic              stop = 1'b0;
    logic              xout = 1'b0;
    logic              int_fall;
    logic [7:0]        p1_per = 8'hff;
    logic [7:0]        p4_per = 8'hff;
    logic [7:0]        p1_ext = 8'h3c;
    logic [7:0]        p4_ext = 8'h00;
    logic [7:0]        p4_een = 8'h00;
    logic [2:0]        p2_ext = 3'h0;
    logic [2:0]        p2_een = 3'h0;
    logic [7:0]        p3_ext = 8'h00;
    logic [7:0]        p3_een = 8'h00;
    logic              xtal_in;
    logic              stop_pin;
    logic [7:0]        p4_lv;
    logic [7:0]        p1_o, p1_e, p1_i, p1_lv, p3_o, p3_e, p3_i, p4_o, p4_e, p4_i;
    logic [2:0]        p2_o, p2_e, p2_i;
    int                error_cnt = 0;
    int                n_compared = 0;

    always #5 mclk = ~mclk;

    mgpio_top u_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .global_output_gate(gate), .dual_clock_mode(dual),
        .stop_mode(stop), .p1_pin_in(p1_i), .p1_pin_out(p1_o), .p1_pin_oe(p1_e), .p1_periph_out(p1_per),
        .p1_level(p1_lv), .p2_pin_in(p2_i), .p2_pin_out(p2_o), .p2_pin_oe(p2_e), .low_freq_crystal_out(xout),
        .low_freq_crystal_in(xtal_in), .stop_release_pin(stop_pin), .ext_int0_fall(int_fall), .p3_pin_in(p3_i),
        .p3_pin_out(p3_o), .p3_pin_oe(p3_e), .p4_pin_in(p4_i), .p4_pin_out(p4_o), .p4_pin_oe(p4_e),
        .p4_periph_out(p4_per), .p4_level(p4_lv));
    mgpio_pad_model #(.W(8)) u_p1 (.pin_out(p1_o), .pin_oe(p1_e), .ext_val(p1_ext), .ext_en(8'hff), .level(p1_i));
    mgpio_pad_model #(.W(3)) u_p2 (.pin_out(p2_o), .pin_oe(p2_e), .ext_val(p2_ext), .ext_en(p2_een), .level(p2_i));
    mgpio_pad_model #(.W(8)) u_p3 (.pin_out(p3_o), .pin_oe(p3_e), .ext_val(p3_ext), .ext_en(p3_een), .level(p3_i));
    mgpio_pad_model #(.W(8)) u_p4 (.pin_out(p4_o), .pin_oe(p4_e), .ext_val(p4_ext), .ext_en(p4_een), .level(p4_i));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd_chk

    // pins answer one cycle after their cause; the pad loop adds one more
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk(p1_e, 8'h00);
        rd_chk(OFF_P1_DIR, 8'h00);
        rd_chk(OFF_P1_DATA, 8'h3c);
        rd_chk(OFF_P2_DATA, 8'h07);
        rd_chk(OFF_P3_DATA, 8'hff);
        rd_chk(OFF_P4_DATA, 8'hff);
        rd_chk(OFF_P4_TYPE, 8'h00);
        wr(OFF_P1_DIR, 8'hff);
        rd_chk(OFF_P1_DATA, 8'h00);
        wr(OFF_P1_DIR, 8'h00);
    endtask : t_reset

    task automatic t_port1();
        wr(OFF_P1_DATA, 8'ha5);
        wr(OFF_P1_DIR, 8'h0f);
        settle();
        chk(p1_e, 8'h0f);
        chk(p1_o, 8'ha5);
        p1_per <= 8'h33;
        settle();
        chk(p1_o, 8'h21);
        chk(p1_lv, 8'h31);
        rd_chk(OFF_P1_DATA, 8'h35);
        wr(OFF_P1_DIR, 8'h00);
        settle();
        chk(p1_e, 8'h00);
    endtask : t_port1

    task automatic t_port4();
        wr(OFF_P4_DATA, 8'h5a);
        wr(OFF_P4_TYPE, 8'h0f);
        settle();
        chk(p4_e, 8'haf);
        chk(p4_o, 8'h0a);
        rd_chk(OFF_P4_PINS, 8'h5a);
        wr(OFF_P4_DATA, 8'hff);
        wr(OFF_P4_TYPE, 8'h00);
        p4_ext <= 8'h7e;
        p4_een <= 8'hff;
        settle();
        chk(p4_e, 8'h00);
        rd_chk(OFF_P4_PINS, 8'h7e);
        rd_chk(OFF_P4_DATA, 8'hff);
        p4_per <= 8'h0f;
        settle();
        chk(p4_e, 8'hf0);
        chk(p4_lv, 8'h0e);
        p4_per <= 8'hff;
    endtask : t_port4

    task automatic t_port23();
        int hits;
        hits = 0;
        wr(OFF_P3_DATA, 8'h0f);
        settle();
        chk(p3_e, 8'hf0);
        rd_chk(OFF_P3_PINS, 8'h0f);
        wr(OFF_P3_DATA, 8'hff);
        p3_ext <= 8'ha5;
        p3_een <= 8'hff;
        settle();
        rd_chk(OFF_P3_PINS, 8'ha5);
        rd_chk(OFF_P3_DATA, 8'hff);
        wr(OFF_P2_DATA, 8'h06);
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            if (int_fall === 1'b1) hits++;
        end
        chk(8'(hits), 8'h01);
        chk({7'h0, stop_pin}, 8'h00);
        rd_chk(OFF_P2_DATA, 8'h06);
        rd_chk(OFF_P2_PINS, 8'h06);
        stop <= 1'b1;
        settle();
        chk({5'h0, p2_e}, 8'h00);
        chk({7'h0, stop_pin}, 8'h01);
        p2_een <= 3'h1;
        settle();
        chk({7'h0, stop_pin}, 8'h00);
        p2_een <= 3'h0;
        stop <= 1'b0;
        dual <= 1'b1;
        xout <= 1'b1;
        wr(OFF_P2_DATA, 8'h00);
        settle();
        chk({5'h0, p2_e}, 8'h05);
        chk({5'h0, p2_o}, 8'h04);
        chk({7'h0, xtal_in}, 8'h01);
        dual <= 1'b0;
        wr(OFF_P2_DATA, 8'h07);
        settle();
        chk({5'h0, p2_e}, 8'h00);
        chk({7'h0, xtal_in}, 8'h00);
    endtask : t_port23

    task automatic t_misc();
        wr(OFF_P1_DIR, 8'hff);
        wr(12'h0ff, 8'h00);
        rd_chk(12'h0ff, 8'h00);
        rd_chk(OFF_P1_DIR, 8'hff);
        gate <= 1'b0;
        settle();
        chk(p1_e, 8'h00);
        gate <= 1'b1;
        settle();
        chk(p1_e, 8'hff);
        // second reset in mid-run must undo the written direction
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        rd_chk(OFF_P1_DIR, 8'h00);
    endtask : t_misc

    // ------------------------------------------------------------------
    // verdict and main sequence
    // ------------------------------------------------------------------
    task automatic summarize();
        $display("errors=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        t_reset();
        t_port1();
        t_port4();
        t_port23();
        t_misc();
        summarize();
    end
endmodule : tb_top
